/* core/list_dwell_step_sequencer.sv */
// module: list sequencer with setpoint, dwell and order tables
`timescale 1ns/1ps
module list_dwell_step_sequencer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic list_clear,
	input wire logic main_channel_select,
	input wire logic voltage_setpoint_append,
	input wire logic current_setpoint_append,
	input wire logic [order_table_write_pkg::SP_W-1:0] setpoint_in,
	input wire logic dwell_table_write,
	input wire logic [order_table_write_pkg::DWELL_W-1:0] dwell_in,
	input wire logic order_table_write,
	input wire logic [order_table_write_pkg::IDX_W-1:0] order_in,
	input wire logic query_pointer_set,
	input wire logic [order_table_write_pkg::IDX_W-1:0] query_in,
	input wire logic repeat_count_write,
	input wire logic [7:0] repeat_count,
	input wire logic leading_step_skip_write,
	input wire logic [7:0] leading_step_skip,
	input wire logic direction_write,
	input wire logic direction_down,
	input wire logic order_source_write,
	input wire logic order_source_select,
	input wire logic list_run_select,
	input wire logic list_stop,
	input wire logic table_read,
	input wire logic [1:0] table_read_sel,
	output logic read_valid,
	output logic read_last,
	output logic [order_table_write_pkg::SP_W-1:0] read_data,
	output order_table_write_pkg::fill_s fill_counts,
	output logic running,
	output logic settings_conflict,
	output logic dwell_rejected,
	output logic channel_is_current,
	output logic [order_table_write_pkg::SP_W-1:0] setpoint_out
);
	logic [order_table_write_pkg::SP_W-1:0] sp_mem [order_table_write_pkg::DATA_DEPTH];
	logic [order_table_write_pkg::DWELL_W-1:0] dw_mem [order_table_write_pkg::DATA_DEPTH];
	logic [order_table_write_pkg::IDX_W-1:0] ord_mem [order_table_write_pkg::ORDER_DEPTH];

	typedef enum logic [1:0] {
		st_idle,
		st_load,
		st_dwell,
		st_read
	} run_e;

	run_e state_r, state_nxt;
	order_table_write_pkg::fill_s fill_r, fill_nxt;
	logic [7:0] count_r, count_nxt, skip_r, skip_nxt;
	logic down_r, down_nxt, user_r, user_nxt, chan_r, chan_nxt;
	logic [order_table_write_pkg::IDX_W-1:0] step_r, step_nxt, len_r, len_nxt;
	logic [7:0] pass_r, pass_nxt;
	logic [order_table_write_pkg::SP_W-1:0] out_r, out_nxt;
	logic conflict_r, conflict_nxt, rej_r, rej_nxt;
	logic [4:0] rcnt_r, rcnt_nxt;
	logic [1:0] rsel_r, rsel_nxt;
	logic [order_table_write_pkg::IDX_W-1:0] raddr_r, raddr_nxt;
	logic rvalid_nxt, rlast_nxt;
	logic [order_table_write_pkg::SP_W-1:0] rdata_nxt;
	logic sp_we, dw_we, ord_we;
	logic load_timer, expire;
	logic [order_table_write_pkg::IDX_W-1:0] data_idx;
	logic [order_table_write_pkg::IDX_W-1:0] first_step;

	// position within the run maps to a data location
	function automatic logic [order_table_write_pkg::IDX_W-1:0] step_loc(
		input logic [order_table_write_pkg::IDX_W-1:0] pos,
		input logic [order_table_write_pkg::IDX_W-1:0] len,
		input logic down);
		step_loc = down ? (len - pos - 10'h001) : pos;
	endfunction : step_loc

	function automatic logic [order_table_write_pkg::IDX_W-1:0] bump(input logic [order_table_write_pkg::IDX_W-1:0] v);
		bump = v + 10'h001;
	endfunction : bump

	assign data_idx = user_r ? ord_mem[9'(step_loc(step_r, len_r, down_r))] : step_loc(step_r, len_r, down_r);
	// restart location at the wrap; the first pass always starts at zero, so it runs whole
	assign first_step = (!down_r && 10'(skip_r) < len_r) ? 10'(skip_r) : 10'h000;

	dwell_tick_timer timer (
		.mclk(mclk),
		.rst(rst),
		.load(load_timer),
		.units((fill_r.dwell_fill == 10'h001) ? dw_mem[0] : dw_mem[data_idx]),
		.expire(expire)
	);

	always_comb begin
		state_nxt = state_r;
		fill_nxt = fill_r;
		count_nxt = count_r;
		skip_nxt = skip_r;
		down_nxt = down_r;
		user_nxt = user_r;
		chan_nxt = chan_r;
		step_nxt = step_r;
		len_nxt = len_r;
		pass_nxt = pass_r;
		out_nxt = out_r;
		conflict_nxt = 1'b0;
		rej_nxt = 1'b0;
		rcnt_nxt = rcnt_r;
		rsel_nxt = rsel_r;
		raddr_nxt = raddr_r;
		rvalid_nxt = 1'b0;
		rlast_nxt = 1'b0;
		rdata_nxt = read_data;
		sp_we = 1'b0;
		dw_we = 1'b0;
		ord_we = 1'b0;
		load_timer = 1'b0;
		case (state_r)
			st_idle: begin
				// table edits are taken only while idle; host must not edit during a run
				if (list_clear) begin
					fill_nxt = '0;
					count_nxt = order_table_write_pkg::COUNT_RESET;
					skip_nxt = order_table_write_pkg::SKIP_RESET;
					down_nxt = 1'b0;
					user_nxt = 1'b0;
				end else if ((voltage_setpoint_append && !chan_r) || (current_setpoint_append && chan_r)) begin
					if (32'(fill_r.setpoint_fill) < order_table_write_pkg::DATA_DEPTH) begin
						sp_we = 1'b1;
						fill_nxt.setpoint_fill = bump(fill_r.setpoint_fill);
					end
				end else if (dwell_table_write) begin
					if (dwell_in < order_table_write_pkg::DWELL_MIN || dwell_in > order_table_write_pkg::DWELL_MAX
						|| 32'(fill_r.dwell_fill) >= order_table_write_pkg::DATA_DEPTH) begin
						rej_nxt = 1'b1;
					end else begin
						dw_we = 1'b1;
						fill_nxt.dwell_fill = bump(fill_r.dwell_fill);
					end
				end else if (order_table_write) begin
					if (32'(fill_r.order_fill) < order_table_write_pkg::ORDER_DEPTH) begin
						ord_we = 1'b1;
						fill_nxt.order_fill = bump(fill_r.order_fill);
					end
				end else if (query_pointer_set) begin
					fill_nxt.query_ptr = query_in;
				end else if (repeat_count_write) begin
					count_nxt = repeat_count;
				end else if (leading_step_skip_write) begin
					skip_nxt = leading_step_skip;
				end else if (direction_write) begin
					down_nxt = direction_down;
				end else if (order_source_write) begin
					user_nxt = order_source_select;
				end else if (main_channel_select != chan_r) begin
					chan_nxt = main_channel_select;
				end else if (table_read) begin
					state_nxt = st_read;
					rsel_nxt = table_read_sel;
					raddr_nxt = fill_r.query_ptr;
					rcnt_nxt = 5'h00;
				end else if (list_run_select) begin
					if (fill_r.setpoint_fill == 10'h000 || (fill_r.dwell_fill != 10'h001
						&& fill_r.dwell_fill != fill_r.setpoint_fill)
						|| (user_r && fill_r.order_fill == 10'h000)) begin
						conflict_nxt = 1'b1;
					end else begin
						state_nxt = st_load;
						len_nxt = user_r ? fill_r.order_fill : fill_r.setpoint_fill;
						step_nxt = 10'h000;
						pass_nxt = 8'h00;
					end
				end
			end
			st_load: begin
				out_nxt = sp_mem[data_idx];
				load_timer = 1'b1;
				state_nxt = st_dwell;
			end
			st_dwell: begin
				if (list_stop) begin
					state_nxt = st_idle;
				end else if (expire) begin
					if (bump(step_r) < len_r) begin
						step_nxt = bump(step_r);
						state_nxt = st_load;
					end else if (count_r != 8'h00 && pass_r + 8'h01 >= count_r) begin
						state_nxt = st_idle;
					end else begin
						// abrupt wrap back to first_step, past the leading skip when counting up
						pass_nxt = (pass_r == 8'hFF) ? pass_r : pass_r + 8'h01;
						step_nxt = first_step;
						state_nxt = st_load;
					end
				end
			end
			st_read: begin
				case (rsel_r)
					2'(order_table_write_pkg::tab_dwell): rdata_nxt = 16'(dw_mem[raddr_r]);
					2'(order_table_write_pkg::tab_order): rdata_nxt = 16'(ord_mem[9'(raddr_r)]);
					default: rdata_nxt = sp_mem[raddr_r];
				endcase
				rvalid_nxt = 1'b1;
				rcnt_nxt = rcnt_r + 5'h01;
				raddr_nxt = bump(raddr_r);
				// ends at 16 values or at the table fill, whichever comes first
				if (rcnt_r == 5'(order_table_write_pkg::READ_BURST - 1) || bump(raddr_r) >= (rsel_r == 2'(order_table_write_pkg::tab_dwell)
					? fill_r.dwell_fill : rsel_r == 2'(order_table_write_pkg::tab_order) ? fill_r.order_fill
					: fill_r.setpoint_fill)) begin
					rlast_nxt = 1'b1;
					state_nxt = st_idle;
				end
			end
			default: state_nxt = st_idle;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sp_we) begin
			sp_mem[fill_r.setpoint_fill] <= setpoint_in;
		end
		if (dw_we) begin
			dw_mem[fill_r.dwell_fill] <= dwell_in;
		end
		if (ord_we) begin
			ord_mem[9'(fill_r.order_fill)] <= order_in;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= st_idle;
			fill_r <= '0;
			count_r <= order_table_write_pkg::COUNT_RESET;
			skip_r <= order_table_write_pkg::SKIP_RESET;
			down_r <= 1'b0;
			user_r <= 1'b0;
			chan_r <= 1'b0;
			step_r <= order_table_write_pkg::PTR_RESET;
			len_r <= order_table_write_pkg::PTR_RESET;
			pass_r <= 8'h00;
			out_r <= 16'h0000;
			conflict_r <= 1'b0;
			rej_r <= 1'b0;
			rcnt_r <= 5'h00;
			rsel_r <= 2'h0;
			raddr_r <= order_table_write_pkg::PTR_RESET;
			read_valid <= 1'b0;
			read_last <= 1'b0;
			read_data <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			fill_r <= fill_nxt;
			count_r <= count_nxt;
			skip_r <= skip_nxt;
			down_r <= down_nxt;
			user_r <= user_nxt;
			chan_r <= chan_nxt;
			step_r <= step_nxt;
			len_r <= len_nxt;
			pass_r <= pass_nxt;
			out_r <= out_nxt;
			conflict_r <= conflict_nxt;
			rej_r <= rej_nxt;
			rcnt_r <= rcnt_nxt;
			rsel_r <= rsel_nxt;
			raddr_r <= raddr_nxt;
			read_valid <= rvalid_nxt;
			read_last <= rlast_nxt;
			read_data <= rdata_nxt;
		end
	end

	assign fill_counts = fill_r;
	assign running = (state_r == st_load) || (state_r == st_dwell);
	assign settings_conflict = conflict_r;
	assign dwell_rejected = rej_r;
	assign channel_is_current = chan_r;
	assign setpoint_out = out_r;
endmodule : list_dwell_step_sequencer

/* core/order_table_write_pkg.sv */
// package: constants and carrier types for the list dwell step sequencer
package order_table_write_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int DATA_DEPTH = 1002;
	localparam int ORDER_DEPTH = 512;
	localparam int READ_BURST = 16;
	localparam int IDX_W = 10;
	localparam int SP_W = 16;
	// dwell is held in units of 0.5 ms: 0.0005 s = 1, 10 s = 20000
	localparam int DWELL_W = 15;
	localparam logic [DWELL_W-1:0] DWELL_MIN = 15'h0001;
	localparam logic [DWELL_W-1:0] DWELL_MAX = 15'h4E20;
	localparam real DWELL_UNIT_S = 0.0005;
	localparam int unsigned DWELL_UNIT_CYC = int'(DWELL_UNIT_S * CLK_HZ);
	localparam logic [IDX_W-1:0] PTR_RESET = 10'h000;
	localparam logic [7:0] COUNT_RESET = 8'h01;
	localparam logic [7:0] SKIP_RESET = 8'h00;

	typedef enum logic [1:0] {
		tab_setpoint,
		tab_dwell,
		tab_order
	} table_e;

	typedef struct packed {
		logic [IDX_W-1:0] setpoint_fill;
		logic [IDX_W-1:0] dwell_fill;
		logic [IDX_W-1:0] order_fill;
		logic [IDX_W-1:0] query_ptr;
	} fill_s;
endpackage : order_table_write_pkg

/* core/dwell_tick_timer.sv */
// module: dwell timer counting 0.5 ms units of clock ticks
`timescale 1ns/1ps
module dwell_tick_timer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic [order_table_write_pkg::DWELL_W-1:0] units,
	output logic expire
);
	localparam logic [15:0] UNIT_LAST = 16'(order_table_write_pkg::DWELL_UNIT_CYC - 1);
	logic [15:0] tick_r, tick_nxt;
	logic [order_table_write_pkg::DWELL_W-1:0] left_r, left_nxt;
	logic busy_r, busy_nxt;
	logic expire_nxt;

	always_comb begin
		tick_nxt = tick_r;
		left_nxt = left_r;
		busy_nxt = busy_r;
		expire_nxt = 1'b0;
		if (load) begin
			tick_nxt = 16'h0000;
			left_nxt = units;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (tick_r == UNIT_LAST) begin
				tick_nxt = 16'h0000;
				if (left_r <= 15'h0001) begin
					busy_nxt = 1'b0;
					expire_nxt = 1'b1;
				end else begin
					left_nxt = left_r - 15'h0001;
				end
			end else begin
				tick_nxt = tick_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_r <= 16'h0000;
			left_r <= 15'h0000;
			busy_r <= 1'b0;
			expire <= 1'b0;
		end else begin
			tick_r <= tick_nxt;
			left_r <= left_nxt;
			busy_r <= busy_nxt;
			expire <= expire_nxt;
		end
	end
endmodule : dwell_tick_timer

/* verification/order_table_write_properties.sv */
// checker: port-level properties of the list sequencer
`timescale 1ns/1ps
module order_table_write_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic list_clear,
	input wire logic voltage_setpoint_append,
	input wire logic current_setpoint_append,
	input wire logic dwell_table_write,
	input wire logic [order_table_write_pkg::DWELL_W-1:0] dwell_in,
	input wire logic list_run_select,
	input wire logic read_valid,
	input wire logic read_last,
	input wire order_table_write_pkg::fill_s fill_counts,
	input wire logic running,
	input wire logic settings_conflict,
	input wire logic dwell_rejected,
	input wire logic channel_is_current,
	input wire logic [order_table_write_pkg::SP_W-1:0] setpoint_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic dw_go;
	// reading state is only partly visible here, so strobes are never issued mid-read
	assign dw_go = dwell_table_write && !running && !read_valid && !list_clear && !voltage_setpoint_append
		&& !current_setpoint_append;
	a_dwell_advance: assert property (
		dw_go && dwell_in != 0 && dwell_in <= order_table_write_pkg::DWELL_MAX && fill_counts.dwell_fill != 10'h3ea
		|=> fill_counts.dwell_fill == $past(fill_counts.dwell_fill) + 1) else $error("dwell fill did not advance");
	a_dwell_reject: assert property (
		dw_go && (dwell_in == 0 || dwell_in > order_table_write_pkg::DWELL_MAX) |-> ##[1:2] dwell_rejected)
		else $error("bad dwell not rejected");
	a_reject_hold: assert property (
		dwell_rejected |-> $stable(fill_counts.dwell_fill)) else $error("rejected dwell moved fill");
	a_empty_refused: assert property (
		list_run_select && !running && !read_valid && !list_clear && !dwell_table_write
		&& !voltage_setpoint_append && fill_counts.setpoint_fill == 0 |-> ##[1:2] settings_conflict)
		else $error("empty run not refused");
	a_conflict_idle: assert property (
		settings_conflict |-> !running) else $error("conflict while running");
	a_last_valid: assert property (
		read_last |-> read_valid) else $error("read last without valid");
	a_clear_zero: assert property (
		list_clear && !running && !read_valid |=> fill_counts == '0) else $error("clear left pointers");
	a_idle_hold: assert property (
		!running && !$past(running) |-> $stable(setpoint_out)) else $error("output moved while idle");
	a_chan_stable: assert property (
		running |-> $stable(channel_is_current)) else $error("channel changed in run");
endmodule : order_table_write_properties

bind list_dwell_step_sequencer order_table_write_properties i_order_table_write_properties (.mclk, .rst, .list_clear,
	.voltage_setpoint_append, .current_setpoint_append, .dwell_table_write, .dwell_in, .list_run_select,
	.read_valid, .read_last, .fill_counts, .running, .settings_conflict, .dwell_rejected,
	.channel_is_current, .setpoint_out);

/* verification/host_cmd_model.sv */
// partner: host issuing one command strobe at a time
`timescale 1ns/1ps
module host_cmd_model (
	input wire logic mclk,
	output logic [12:0] stb,
	output logic [15:0] dat
);
	initial begin
		stb = '0;
		dat = '0;
	end
	// one strobe, then a gap cycle; tables are loaded only while idle
	task automatic send(input int op, input logic [15:0] d);
		@(posedge mclk);
		stb <= 13'h0001 << op;
		dat <= d;
		@(posedge mclk);
		stb <= '0;
	endtask : send
endmodule : host_cmd_model

/* verification/tb_top.sv */
// testbench: list sequencer scenarios driven through the host model
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [12:0] stb;
	logic chan_sel = 1'b0;
	logic [15:0] dat;
	logic read_valid, read_last, running, settings_conflict, dwell_rejected, channel_is_current;
	logic [15:0] read_data, setpoint_out, prev_sp;
	order_table_write_pkg::fill_s fill_counts;
	logic [15:0] seen[$];
	logic [15:0] words[$];
	int mismatches = 0;
	int tests_run = 0;
	int rej_seen = 0;
	int cf_seen = 0;
	always #20 mclk = ~mclk;
	host_cmd_model i_host_cmd_model (.mclk(mclk), .stb(stb), .dat(dat));
	list_dwell_step_sequencer i_list_dwell_step_sequencer (.mclk(mclk), .rst(rst), .list_clear(stb[0]),
		.main_channel_select(chan_sel), .voltage_setpoint_append(stb[1]), .current_setpoint_append(stb[2]),
		.setpoint_in(dat), .dwell_table_write(stb[3]), .dwell_in(dat[14:0]), .order_table_write(stb[4]),
		.order_in(dat[9:0]), .query_pointer_set(stb[5]), .query_in(dat[9:0]), .repeat_count_write(stb[6]),
		.repeat_count(dat[7:0]), .leading_step_skip_write(stb[7]), .leading_step_skip(dat[7:0]),
		.direction_write(stb[8]), .direction_down(dat[0]), .order_source_write(stb[9]),
		.order_source_select(dat[0]), .list_run_select(stb[10]), .list_stop(stb[12]), .table_read(stb[11]),
		.table_read_sel(dat[1:0]), .read_valid(read_valid), .read_last(read_last), .read_data(read_data),
		.fill_counts(fill_counts), .running(running), .settings_conflict(settings_conflict),
		.dwell_rejected(dwell_rejected), .channel_is_current(channel_is_current), .setpoint_out(setpoint_out));
	// sampled on the falling edge, away from the register updates
	always @(negedge mclk) begin
		if (running === 1'b1 && setpoint_out !== prev_sp)
			seen.push_back(setpoint_out);
		prev_sp = setpoint_out;
		if (dwell_rejected === 1'b1)
			rej_seen++;
		if (settings_conflict === 1'b1)
			cf_seen++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic send(input int op, input logic [15:0] d);
		i_host_cmd_model.send(op, d);
	endtask : send
	task automatic rd_chk(input logic [1:0] sel, input logic [15:0] exp[$]);
		words.delete();
		send(11, {14'h0, sel});
		for (int i = 0; i < 24; i++) begin
			@(negedge mclk);
			if (read_valid === 1'b1)
				words.push_back(read_data);
			if (read_last === 1'b1)
				break;
		end
		chk(16'(words.size()), 16'(exp.size()));
		foreach (exp[i])
			chk(words[i], exp[i]);
	endtask : rd_chk
	// waits out a run and compares the stepped values and the final hold
	task automatic run_chk(input logic [15:0] exp[$]);
		seen.delete();
		send(10, 16'h0000);
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 70000 && running === 1'b1; i++)
			@(posedge mclk);
		@(negedge mclk);
		chk({15'h0, running}, 16'h0000);
		chk(16'(seen.size()), 16'(exp.size()));
		foreach (exp[i])
			chk(seen[i], exp[i]);
		chk(setpoint_out, exp[exp.size()-1]);
	endtask : run_chk
	task automatic t_empty;
		chk(16'(fill_counts.setpoint_fill), 16'h0000);
		send(10, 16'h0000);
		repeat (4) @(negedge mclk);
		chk(16'(cf_seen), 16'h0001);
		chk({15'h0, running}, 16'h0000);
	endtask : t_empty
	task automatic t_load;
		send(1, 16'h0011);
		send(1, 16'h0022);
		send(1, 16'h0033);
		send(3, 16'h0000);
		repeat (3) @(negedge mclk);
		chk(16'(fill_counts.setpoint_fill), 16'h0003);
		chk(16'(fill_counts.dwell_fill), 16'h0000);
		chk(16'(rej_seen), 16'h0001);
		send(3, 16'h0001);
		send(4, 16'h0002);
		send(4, 16'h0000);
		repeat (2) @(negedge mclk);
		chk(16'(fill_counts.dwell_fill), 16'h0001);
		chk(16'(fill_counts.order_fill), 16'h0002);
		chk({15'h0, channel_is_current}, 16'h0000);
		rd_chk(2'd0, '{16'h0011, 16'h0022, 16'h0033});
		rd_chk(2'd1, '{16'h0001});
		rd_chk(2'd2, '{16'h0002, 16'h0000});
		send(5, 16'h0001);
		repeat (2) @(negedge mclk);
		chk(16'(fill_counts.query_ptr), 16'h0001);
		rd_chk(2'd0, '{16'h0022, 16'h0033});
	endtask : t_load
	task automatic t_fwd;
		// one dwell unit per step keeps each step at 12502 cycles
		send(6, 16'h0002);
		send(7, 16'h0001);
		run_chk('{16'h0011, 16'h0022, 16'h0033, 16'h0022, 16'h0033});
	endtask : t_fwd
	task automatic t_rev;
		send(0, 16'h0000);
		repeat (2) @(negedge mclk);
		chk({15'h0, fill_counts !== '0}, 16'h0000);
		send(1, 16'h0044);
		send(1, 16'h0055);
		send(3, 16'h0001);
		send(8, 16'h0001);
		send(7, 16'h0001);
		run_chk('{16'h0055, 16'h0044});
	endtask : t_rev
	// current channel, user order of one entry, repeat zero: still running after a pass, then stopped
	task automatic t_user;
		send(0, 16'h0000);
		@(posedge mclk);
		chan_sel <= 1'b1;
		repeat (2) @(negedge mclk);
		chk({15'h0, channel_is_current}, 16'h0001);
		send(1, 16'h0099);
		send(2, 16'h0066);
		send(2, 16'h0077);
		send(3, 16'h0001);
		send(9, 16'h0001);
		send(10, 16'h0000);
		repeat (3) @(negedge mclk);
		chk(16'(cf_seen), 16'h0002);
		chk(16'(fill_counts.setpoint_fill), 16'h0002);
		send(4, 16'h0001);
		send(6, 16'h0000);
		send(10, 16'h0000);
		repeat (3) @(negedge mclk);
		chk(setpoint_out, 16'h0077);
		repeat (12520) @(negedge mclk);
		chk({15'h0, running}, 16'h0001);
		send(12, 16'h0000);
		repeat (2) @(negedge mclk);
		chk({15'h0, running}, 16'h0000);
		chk(setpoint_out, 16'h0077);
	endtask : t_user
	task automatic end_sim;
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_empty();
		t_load();
		t_fwd();
		t_rev();
		t_user();
		end_sim();
	end
	initial begin
		#4160000;
		mismatches++;
		end_sim();
	end
endmodule : tb_top
